/* rtl/vcl_consts.svh */
`ifndef VCL_CONSTS_SVH
`define VCL_CONSTS_SVH

// program-space window where the configuration bytes appear
`define VCL_CFG_BASE 22'h30_0000
// upper address bits that select the configuration window
`define VCL_CFG_BASE_HI 19'h6_0000
// word address of the lowest of the four top flash words
`define VCL_FL_CFG_WORD0 13'h1FFC
// number of configuration words fetched at power-up
`define VCL_CFG_WORDS 3'h4
// index of the last word fetched
`define VCL_CFG_LAST_IDX 2'h3
// implemented configuration bits, word 1 in the low 16 bits
`define VCL_IMPL_MASK 64'hFFFF_0FFF_0FFF_0FFF
// erased / power-on value of every configuration bit
`define VCL_CFG_ERASED 64'hFFFF_FFFF_FFFF_FFFF

`endif

/* rtl/vcl_pkg.sv */
package vcl_pkg;

  // loader sequence, one-hot
  typedef enum logic [2:0] {
    VCL_ST_READ = 3'b001,
    VCL_ST_WAIT = 3'b010,
    VCL_ST_DONE = 3'b100
  } vcl_state_e;

  // answer to a program-space read of the configuration window
  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } vcl_rd_s;

  // a byte write toward the configuration window
  typedef struct packed {
    logic en;
    logic [21:0] addr;
    logic [7:0] data;
  } vcl_wr_s;

endpackage

/* rtl/vcl_loader.sv */
// What this block does
// - programmed bit reads zero, erased bit one
// - config bytes appear at fixed program base
// - source is the four top flash words
// - words ascend, first low byte lowest address
// - every power-up copies flash words into registers
// - power-on reset sets all config bits one
// - other resets keep values, no reload
// - unused upper bits have no storage
// - each bit writable once per power cycle
// - new config takes effect only via reset
`include "vcl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module vcl_loader (
  input wire logic CLK_SYS_IN, // 40 MHz core clock
  input wire logic RSTN_IN, // power-on reset, async, low
  input wire logic SYS_RSTN_IN, // any other device reset, pin
  output logic [12:0] FL_ADDR_OUT, // flash word address
  output logic FL_RD_OUT, // flash read strobe, one cycle
  input wire logic [15:0] FL_DATA_IN, // flash read word
  input wire logic FL_VALID_IN, // flash word valid, one cycle
  input wire logic TBL_RD_IN, // program-space byte read
  input wire logic [21:0] TBL_ADDR_IN, // program-space byte address
  output vcl_pkg::vcl_rd_s TBL_RD_OUT, // read answer, next cycle
  input wire vcl_pkg::vcl_wr_s CFG_WR_IN, // config byte write
  output logic [63:0] CFG_ACTIVE_OUT, // configuration in force
  output logic CORE_RSTN_OUT, // core reset, low holds core
  output logic LOAD_DONE_OUT // power-up load complete
);
  import vcl_pkg::*;

  // loader state and word counter
  vcl_state_e state_reg, state_next;
  logic [1:0] idx_reg, idx_next;
  // stored configuration and per-bit write-once locks
  logic [63:0] cfg_reg, cfg_next;
  logic [63:0] lock_reg, lock_next;
  // configuration presented to the device
  logic [63:0] act_reg;
  // flash request registers
  logic [12:0] fl_addr_reg;
  logic fl_rd_reg;
  // reset pin synchroniser, first stage feeds only second
  logic sys_meta_reg, sys_sync_reg;
  logic core_rstn_reg;
  vcl_rd_s rd_reg, rd_next;

  // decodes
  wire st_read = (state_reg == VCL_ST_READ);
  wire st_wait = (state_reg == VCL_ST_WAIT);
  wire st_done = (state_reg == VCL_ST_DONE);
  wire ld_take = st_wait && FL_VALID_IN;
  wire ld_last = ld_take && (idx_reg == `VCL_CFG_LAST_IDX);
  // 16-bit word lane inside the 8-byte window, low address = word 1 low
  wire [5:0] ld_shift = {idx_reg, 4'h0};
  // unimplemented bits forced to one, never stored
  wire [63:0] ld_word = {48'h0000_0000_0000, FL_DATA_IN} << ld_shift;
  wire [63:0] ld_lane = {48'h0000_0000_0000, 16'hFFFF} << ld_shift;
  wire [63:0] impl = `VCL_IMPL_MASK;

  // program-space window decodes
  wire tbl_hit = TBL_RD_IN &&
    (TBL_ADDR_IN[21:3] == `VCL_CFG_BASE_HI);
  wire [5:0] tbl_shift = {TBL_ADDR_IN[2:0], 3'h0};
  wire [63:0] tbl_word = cfg_reg >> tbl_shift;
  // writes only while the core runs and no reset is pending,
  // so a device reset never races them
  wire wr_hit = CFG_WR_IN.en && st_done && core_rstn_reg &&
    sys_sync_reg && (CFG_WR_IN.addr[21:3] == `VCL_CFG_BASE_HI);
  wire [5:0] wr_shift = {CFG_WR_IN.addr[2:0], 3'h0};
  // a zero written programs the bit; ones are no-ops
  wire [63:0] wr_zero = {56'h0000_0000_0000_00, ~CFG_WR_IN.data}
    << wr_shift;
  // a bit already programmed this power cycle is locked
  wire [63:0] wr_prog = wr_hit ? (wr_zero & ~lock_reg & impl)
    : 64'h0000_0000_0000_0000;

  // next state of the power-up load sequence
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    case (state_reg)
      VCL_ST_READ: begin
        // strobe loaded into the output register this cycle, on FL_RD_OUT in the wait state
        state_next = VCL_ST_WAIT;
      end
      VCL_ST_WAIT: begin
        if (ld_last) begin
          state_next = VCL_ST_DONE;
        end else if (ld_take) begin
          idx_next = idx_reg + 2'h1;
          state_next = VCL_ST_READ;
        end
      end
      VCL_ST_DONE: begin
        // stays here until the next power-on reset
        state_next = VCL_ST_DONE;
      end
      default: begin
        state_next = VCL_ST_READ;
      end
    endcase
  end

  // configuration bits: load lane, then write-once programming
  always_comb begin
    cfg_next = cfg_reg;
    lock_next = lock_reg;
    if (ld_take) begin
      // flash bits copied straight: zero means programmed
      cfg_next = (cfg_reg & ~ld_lane) |
        ((ld_word | ~impl) & ld_lane);
      // bits that arrive programmed may not be rewritten
      lock_next = lock_reg | (~ld_word & ld_lane & impl);
    end else begin
      cfg_next = cfg_reg & ~wr_prog;
      lock_next = lock_reg | wr_prog;
    end
  end

  // program-space read answer
  always_comb begin
    rd_next.hit = tbl_hit;
    rd_next.data = tbl_hit ? tbl_word[7:0] : 8'h00;
  end

  // sequencer registers; power-on restarts the load
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg <= VCL_ST_READ;
      idx_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  // configuration cells, all ones at power-on only
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cfg_reg <= `VCL_CFG_ERASED;
      lock_reg <= 64'h0000_0000_0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      lock_reg <= lock_next;
    end
  end

  // flash request: address of the top words, in ascending order
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      fl_addr_reg <= `VCL_FL_CFG_WORD0;
      fl_rd_reg <= 1'b0;
    end else begin
      fl_addr_reg <= `VCL_FL_CFG_WORD0 + {11'h000, idx_next};
      // strobe follows the read state, so the first one is not lost
      fl_rd_reg <= st_read;
    end
  end

  // two flops on the external reset pin
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sys_meta_reg <= 1'b0;
      sys_sync_reg <= 1'b0;
    end else begin
      sys_meta_reg <= SYS_RSTN_IN;
      sys_sync_reg <= sys_meta_reg;
    end
  end

  // applied configuration only changes at load end or in reset;
  // a running core never sees a bit flip under it
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      act_reg <= `VCL_CFG_ERASED;
    end else if (ld_last) begin
      act_reg <= cfg_next;
    end else if (st_done && !sys_sync_reg) begin
      act_reg <= cfg_reg;
    end
  end

  // core released only after the load and outside any reset
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      core_rstn_reg <= 1'b0;
    end else begin
      core_rstn_reg <= st_done && sys_sync_reg;
    end
  end

  // read answer register
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // outputs straight from flops
  assign FL_ADDR_OUT = fl_addr_reg;
  assign FL_RD_OUT = fl_rd_reg;
  assign TBL_RD_OUT = rd_reg;
  assign CFG_ACTIVE_OUT = act_reg;
  assign CORE_RSTN_OUT = core_rstn_reg;
  assign LOAD_DONE_OUT = state_reg[2]; // done bit of the one-hot

  // checks, all on the core clock under power-on reset
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  // core stays in reset while the load runs
  property p_core_held;
    !st_done |-> !CORE_RSTN_OUT;
  endproperty
  a_core_held: assert property (p_core_held)
    else $error("core released before load done");

  // first request goes to the lowest top word
  property p_first_addr;
    FL_RD_OUT && st_wait && idx_reg == 2'h0 |->
      FL_ADDR_OUT == `VCL_FL_CFG_WORD0;
  endproperty
  a_first_addr: assert property (p_first_addr)
    else $error("first flash word address wrong");

  // each request is one above the previous one
  property p_ascend;
    FL_RD_OUT && idx_reg != 2'h0 |->
      FL_ADDR_OUT == `VCL_FL_CFG_WORD0 + {11'h000, idx_reg};
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("flash words not fetched in ascending order");

  // word 1 lands in the lowest two bytes with its polarity kept
  property p_word1_copy;
    ld_take && idx_reg == 2'h0 |=>
      cfg_reg[15:0] == ($past(FL_DATA_IN) | ~impl[15:0]);
  endproperty
  a_word1_copy: assert property (p_word1_copy)
    else $error("word 1 not copied into low bytes");

  // load starts from all ones
  property p_erased_start;
    st_read && idx_reg == 2'h0 |-> cfg_reg == `VCL_CFG_ERASED;
  endproperty
  a_erased_start: assert property (p_erased_start)
    else $error("config not all ones before load");

  // other resets neither reload nor change the cells
  property p_keep_on_reset;
    st_done && !sys_sync_reg |=> st_done && $stable(cfg_reg);
  endproperty
  a_keep_on_reset: assert property (p_keep_on_reset)
    else $error("config changed by non power-on reset");

  // unimplemented positions always read one
  property p_unimpl_one;
    (cfg_reg & ~impl) == ~impl;
  endproperty
  a_unimpl_one: assert property (p_unimpl_one)
    else $error("unimplemented config bit stored");

  // a locked bit never changes again
  property p_locked;
    1'b1 |=> ((cfg_reg ^ $past(cfg_reg)) & $past(lock_reg)) == '0;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked config bit rewritten");

  // applied config is frozen while the core keeps running
  property p_frozen;
    CORE_RSTN_OUT ##1 CORE_RSTN_OUT |-> $stable(CFG_ACTIVE_OUT);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("config changed while core running");

  // a window read answers next cycle with the stored byte
  property p_tbl_read;
    tbl_hit |=> TBL_RD_OUT.hit && TBL_RD_OUT.data == $past(tbl_word[7:0]);
  endproperty
  a_tbl_read: assert property (p_tbl_read)
    else $error("config window read wrong");

  // main scenarios
  property p_cov_load;
    ld_last ##1 st_done;
  endproperty
  c_cov_load: cover property (p_cov_load);
  property p_cov_prog;
    wr_prog != '0;
  endproperty
  c_cov_prog: cover property (p_cov_prog);
  property p_cov_sysrst;
    st_done && !sys_sync_reg ##1 sys_sync_reg;
  endproperty
  c_cov_sysrst: cover property (p_cov_sysrst);
  property p_cov_read;
    tbl_hit;
  endproperty
  c_cov_read: cover property (p_cov_read);

endmodule

`default_nettype wire

/* tb/vcl_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

module vcl_flash_model (
  input wire logic clk_in, // core clock
  input wire logic [12:0] addr_in, // flash word address
  input wire logic rd_in, // read strobe
  output logic [15:0] data_out, // read word
  output logic valid_out // word valid pulse
);
  logic [15:0] mem [0:3]; // top four words, loaded by the bench
  logic [12:0] a; // latched address
  int dly; // answer latency, cycles through 0..3
  // one read outstanding; latency varies so prompt and slow both occur
  initial begin
    valid_out = 1'b0;
    data_out = 16'h0000;
    dly = 0;
    forever begin
      @(posedge clk_in);
      if (rd_in === 1'b1) begin
        a = addr_in;
        @(negedge clk_in);
        // stale bus toggles so an early sample never sees good data
        repeat (dly) begin
          data_out = ~data_out;
          @(negedge clk_in);
        end
        data_out = mem[a[1:0]];
        valid_out = 1'b1;
        @(negedge clk_in);
        valid_out = 1'b0;
        data_out = ~data_out;
        dly = (dly + 3) % 4;
      end
    end
  end
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import vcl_pkg::*;
  logic clk = 1'b0; // core clock
  logic rstn = 1'b0; // power-on reset, low
  logic sys_rstn = 1'b1; // other device reset, low
  logic tbl_rd = 1'b0; // table read strobe
  logic [21:0] tbl_addr = 22'h00_0000; // table read address
  vcl_wr_s cfg_wr = '0; // config byte write
  logic [12:0] fl_addr; // flash side
  logic fl_rd;
  logic fl_valid;
  logic [15:0] fl_data;
  vcl_rd_s tbl_q; // read answer
  logic [63:0] cfg_act; // configuration in force
  logic core_rstn;
  logic load_done;
  logic [63:0] img; // flash image
  logic [63:0] cells; // expected stored cells
  logic [8:0] exp_q [$]; // expected read answers
  logic rd_d = 1'b0; // read issued last edge
  int mismatches = 0;
  int check_count = 0;
  int rd_cnt = 0; // flash strobes seen
  int seed = 70;
  int n;
  int j;

  always #12.5 clk = ~clk;

  vcl_loader u_vcl_loader (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
    .SYS_RSTN_IN(sys_rstn), .FL_ADDR_OUT(fl_addr), .FL_RD_OUT(fl_rd),
    .FL_DATA_IN(fl_data), .FL_VALID_IN(fl_valid), .TBL_RD_IN(tbl_rd),
    .TBL_ADDR_IN(tbl_addr), .TBL_RD_OUT(tbl_q), .CFG_WR_IN(cfg_wr),
    .CFG_ACTIVE_OUT(cfg_act), .CORE_RSTN_OUT(core_rstn),
    .LOAD_DONE_OUT(load_done));
  vcl_flash_model u_vcl_flash_model (.clk_in(clk), .addr_in(fl_addr),
    .rd_in(fl_rd), .data_out(fl_data), .valid_out(fl_valid));

  // single compare point
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask

  // random flash image, upper nibbles of words 0..2 padded
  task automatic new_image;
    logic [15:0] w;
    for (int k = 0; k < 4; k++) begin
      w = 16'($random(seed));
      if (k < 3) w[15:12] = 4'hF;
      u_vcl_flash_model.mem[k] = w;
      img[16*k +: 16] = w;
    end
  endtask

  // bounded wait for the power-up load, then compare
  task automatic wait_load(input int base);
    int t;
    t = 0;
    while (load_done !== 1'b1 && t < 200) begin
      cyc(1);
      t++;
    end
    check(load_done, 1'b1);
    check(cfg_act, img);
    check(64'(rd_cnt - base), 64'h0000_0000_0000_0004);
    cyc(3);
    check(core_rstn, 1'b1);
    cells = img;
  endtask

  // back to back reads, one below and one above the window
  task automatic rd_all;
    for (int i = 0; i < 10; i++) begin
      tbl_addr = 22'h2F_FFFF + 22'(i);
      tbl_rd = 1'b1;
      exp_q.push_back((i >= 1 && i <= 8) ?
        {1'b1, cells[8*(i-1) +: 8]} : 9'h000);
      cyc(1);
    end
    tbl_rd = 1'b0;
    cyc(2);
  endtask

  // answers show one edge after the request
  always @(posedge clk) rd_d <= tbl_rd;
  always @(posedge clk) if (fl_rd === 1'b1) rd_cnt <= rd_cnt + 1;
  always @(negedge clk) begin
    if (rd_d) check({55'h0, tbl_q}, {55'h0, exp_q.pop_front()});
    if (load_done !== 1'b1) check(core_rstn, 1'b0);
    if (fl_rd === 1'b1)
      check(fl_addr, 13'h1FFC + 13'(rd_cnt % 4));
  end

  // hang guard, far beyond the roughly 150 cycles used
  initial begin
    #200us;
    mismatches++;
    print_verdict();
  end

  initial begin
    new_image();
    cyc(16);
    rstn = 1'b1;
    wait_load(0);
    rd_all();
    $display("test load and readback done");
    // two rounds of writes, second tries to reopen bits, then a stray
    for (j = 0; j < 17; j++) begin
      cfg_wr.en = 1'b1;
      cfg_wr.addr = (j == 16) ? 22'h30_0008 : 22'h30_0000 + 22'(j % 8);
      cfg_wr.data = (j == 16) ? 8'h00 : 8'($random(seed));
      if (j < 16)
        cells[8*(j%8) +: 8] = cells[8*(j%8) +: 8] & (cfg_wr.data |
          (((j % 8) inside {1, 3, 5}) ? 8'hF0 : 8'h00));
      cyc(1);
    end
    cfg_wr.en = 1'b0;
    cyc(1);
    rd_all();
    check(cfg_act, img);
    $display("test write once done");
    n = rd_cnt;
    sys_rstn = 1'b0;
    cyc(6);
    check(core_rstn, 1'b0);
    check(cfg_act, cells);
    sys_rstn = 1'b1;
    cyc(6);
    check(core_rstn, 1'b1);
    check(64'(rd_cnt), 64'(n));
    rd_all();
    $display("test device reset done");
    rstn = 1'b0;
    cyc(2);
    check(cfg_act, 64'hFFFF_FFFF_FFFF_FFFF);
    check(load_done, 1'b0);
    new_image();
    cyc(14);
    n = rd_cnt;
    rstn = 1'b1;
    wait_load(n);
    rd_all();
    $display("test power cycle reload done");
    print_verdict();
  end
endmodule

`default_nettype wire
